// ===== rtl/opaddr_defs.vh
// constants for the operand effective-address generator
`ifndef OPADDR_DEFS_VH
`define OPADDR_DEFS_VH

// ****************************************
// address spaces
// ****************************************
`define SADDR_LO        16'hfe20
`define SADDR_HI        16'hff1f
`define SADDR_HIGH7     7'h7f
`define SADDR_WRAP      8'h20
`define SFR_PAGE        8'hff
`define SFR_HOLE_LO     8'hd0
`define SFR_HOLE_HI     8'hdf
`define HRAM_LO         16'hfb00
`define HRAM_HI         16'hfeff

// ****************************************
// register file layout
// ****************************************
`define BANK_BITS       64
`define REG_X           3'h0
`define REG_A           3'h1
`define REG_C           3'h2
`define REG_B           3'h3
`define REG_E           3'h4
`define REG_D           3'h5
`define REG_L           3'h6
`define REG_H           3'h7

// ****************************************
// opcodes
// ****************************************
`define OP_MOV_A_SADDR  8'hf0
`define OP_MOV_SADDR_A  8'hf2
`define OP_MOV_SADDR_IM 8'h11
`define OP_MOVW_SADDRP  8'h89
`define OP_MOV_A_SFR    8'hf4
`define OP_MOV_SFR_A    8'hf6
`define OP_MOVW_SFRP    8'ha9
`define OP_MOV_A_IND_DE 8'h85
`define OP_MOV_A_IND_HL 8'h87
`define OP_MOV_A_HL_OFS 8'hae
`define OP_MOV_A_HL_B   8'hab
`define OP_MOV_A_HL_C   8'haa
`define OP_PUSH_MASK    8'hf8
`define OP_PUSH_BASE    8'hb0

// ****************************************
// addressing modes
// ****************************************
`define MODE_NONE       3'h0
`define MODE_SHORT      3'h1
`define MODE_SFR        3'h2
`define MODE_INDIRECT   3'h3
`define MODE_BASED      3'h4
`define MODE_BASED_IDX  3'h5
`define MODE_STACK      3'h6

`endif

// ===== rtl/operand_address_generator.v
// operand effective-address generator for the 8-bit core
`timescale 1ns/100ps
`include "opaddr_defs.vh"

module operand_address_generator (
	// clock and reset
	input  wire         core_clk,
	input  wire         rst_n,
	// instruction request
	input  wire         dec_valid,
	input  wire [7:0]   opcode,
	input  wire [7:0]   operand_byte,
	// automatic stack use
	input  wire         stack_push_req,
	input  wire         stack_pop_req,
	// core state
	input  wire         regset_sel0,
	input  wire         regset_sel1,
	input  wire [255:0] gpr_file,
	input  wire [15:0]  stack_ptr,
	// result
	output reg          addr_valid_r,
	output reg  [15:0]  eff_addr_r,
	output reg  [2:0]   addr_mode_r,
	output reg          word_access_r,
	output reg          is_write_r,
	output reg  [15:0]  push_data_r,
	output reg          align_fault_r,
	output reg          range_fault_r,
	output reg          illegal_op_r
);

	// ****************************************
	// helpers
	// ****************************************
	// fetch one 8-bit register of a bank from the flat file
	function [7:0] gpr_byte;
		input [255:0] file;
		input [1:0]   bank;
		input [2:0]   idx;
		reg   [7:0]   slot;
		begin
			slot = {1'b0, bank, idx, 2'b00} >> 2;
			gpr_byte = file[slot*8 +: 8];
		end
	endfunction

	// fetch a register pair, high register is the odd index
	function [15:0] gpr_pair;
		input [255:0] file;
		input [1:0]   bank;
		input [1:0]   pair;
		begin
			gpr_pair = {gpr_byte(file, bank, {pair, 1'b1}),
				gpr_byte(file, bank, {pair, 1'b0})};
		end
	endfunction

	// true when a byte lies inside an inclusive range
	function in_byte_range;
		input [7:0] val;
		input [7:0] lo;
		input [7:0] hi;
		begin
			in_byte_range = (val >= lo) && (val <= hi);
		end
	endfunction

	// true when a whole stack word fits inside high-speed ram
	function stack_word_ok;
		input [15:0] addr;
		begin
			stack_word_ok = (addr >= `HRAM_LO) && (addr <= (`HRAM_HI - 16'h0001));
		end
	endfunction

	// opcode to addressing mode
	function [2:0] mode_of;
		input [7:0] op;
		begin
			case (op)
				`OP_MOV_A_SADDR,
				`OP_MOV_SADDR_A,
				`OP_MOV_SADDR_IM,
				`OP_MOVW_SADDRP: mode_of = `MODE_SHORT;
				`OP_MOV_A_SFR,
				`OP_MOV_SFR_A,
				`OP_MOVW_SFRP:   mode_of = `MODE_SFR;
				`OP_MOV_A_IND_DE,
				`OP_MOV_A_IND_HL: mode_of = `MODE_INDIRECT;
				`OP_MOV_A_HL_OFS: mode_of = `MODE_BASED;
				`OP_MOV_A_HL_B,
				`OP_MOV_A_HL_C:  mode_of = `MODE_BASED_IDX;
				default: begin
					// push and pop of any pair
					if ((op & `OP_PUSH_MASK) == `OP_PUSH_BASE)
						mode_of = `MODE_STACK;
					else
						mode_of = `MODE_NONE;
				end
			endcase
		end
	endfunction

	// ****************************************
	// decode and address forming
	// ****************************************
	wire [1:0]  bank_sel   = {regset_sel1, regset_sel0};
	wire [2:0]  dec_mode   = mode_of(opcode);
	wire        pair_op    = (opcode == `OP_MOVW_SADDRP) || (opcode == `OP_MOVW_SFRP);
	wire        push_op    = opcode[0];

	// ****************************************
	// request arbitration
	// ****************************************
	// automatic stack traffic cannot wait for the decoder,
	// so it always outranks a decoded instruction
	wire        auto_req   = stack_push_req || stack_pop_req;
	// push wins the address when both arrive together
	wire        auto_write = stack_push_req;
	wire        dec_take   = dec_valid && !auto_req;

	// ****************************************
	// selected bank unpacking
	// ****************************************
	// byte and pair views of the selected bank only, so pair
	// and index reads always agree on the bank
	wire [7:0]  bank_byte [0:7];
	wire [15:0] bank_pair [0:3];

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_bank_byte
			localparam [2:0] REG_IDX = g;
			assign bank_byte[g] = gpr_byte(gpr_file, bank_sel, REG_IDX);
		end
		// high register is the odd index
		for (g = 0; g < 4; g = g + 1) begin : g_bank_pair
			localparam [1:0] PAIR_IDX = g;
			assign bank_pair[g] = gpr_pair(gpr_file, bank_sel, PAIR_IDX);
		end
	endgenerate

	// main pair and indexes from the selected bank
	wire [15:0] hl_pair    = bank_pair[3];
	wire [15:0] de_pair    = bank_pair[2];
	wire [7:0]  idx_upper  = bank_byte[`REG_B];
	wire [7:0]  idx_lower  = bank_byte[`REG_C];

	// ****************************************
	// operand qualifiers
	// ****************************************
	// operand_byte is ignored by indirect, indexed and stack modes
	// a read names the accumulator as target or is a word move, the rest write
	wire        short_write = (opcode != `OP_MOV_A_SADDR) && !pair_op;
	wire        sfr_write   = (opcode == `OP_MOV_SFR_A);
	// saddrp and sfrp word operands must sit on an even address
	wire        odd_word    = pair_op && operand_byte[0];

	// ****************************************
	// address candidates
	// ****************************************
	// every mode forms its address in parallel and the decoded
	// mode picks one; a few adders buy a shallow select path
	// bit 8 set only for bytes below the window wrap
	wire        short_page = (operand_byte < `SADDR_WRAP);
	wire [15:0] short_addr = {`SADDR_HIGH7, short_page, operand_byte};
	wire [15:0] sfr_addr   = {`SFR_PAGE, operand_byte};
	// hole between the two register blocks
	wire        sfr_hole   = in_byte_range(operand_byte, `SFR_HOLE_LO, `SFR_HOLE_HI);
	wire [15:0] ind_addr   = opcode[1] ? hl_pair : de_pair;
	wire [7:0]  idx_sel    = opcode[0] ? idx_upper : idx_lower;
	// zero-extended, carry out of bit 15 dropped
	wire [15:0] based_addr = hl_pair + {8'h00, operand_byte};
	wire [15:0] idx_addr   = hl_pair + {8'h00, idx_sel};
	wire [15:0] stack_dn   = stack_ptr - 16'h0002;
	// both candidate stack words checked up front
	wire        push_bad   = !stack_word_ok(stack_dn);
	wire        pop_bad    = !stack_word_ok(stack_ptr);
	wire [15:0] stack_pair = bank_pair[opcode[2:1]];

	reg  [15:0] addr_nxt;
	reg  [2:0]  mode_nxt;
	reg         word_nxt;
	reg         write_nxt;
	reg  [15:0] push_data_nxt;
	reg         align_nxt;
	reg         range_nxt;
	reg         illegal_nxt;
	reg         valid_nxt;

	always @* begin
		addr_nxt      = 16'h0000;
		mode_nxt      = `MODE_NONE;
		word_nxt      = 1'b0;
		write_nxt     = 1'b0;
		push_data_nxt = 16'h0000;
		align_nxt     = 1'b0;
		range_nxt     = 1'b0;
		illegal_nxt   = 1'b0;
		valid_nxt     = 1'b0;
		// automatic stack use outranks a decoded instruction
		if (auto_req) begin
			mode_nxt  = `MODE_STACK;
			word_nxt  = 1'b1;
			write_nxt = auto_write;
			addr_nxt  = auto_write ? stack_dn : stack_ptr;
			valid_nxt = 1'b1;
		end else if (dec_take) begin
			mode_nxt  = dec_mode;
			valid_nxt = 1'b1;
			case (dec_mode)
				`MODE_SHORT: begin
					// window with bit 8 from the byte range
					addr_nxt  = short_addr;
					word_nxt  = pair_op;
					write_nxt = short_write;
					align_nxt = odd_word;
				end
				`MODE_SFR: begin
					addr_nxt  = sfr_addr;
					word_nxt  = pair_op;
					write_nxt = sfr_write;
					align_nxt = odd_word;
					range_nxt = sfr_hole;
				end
				`MODE_INDIRECT: begin
					addr_nxt = ind_addr;
				end
				`MODE_BASED: begin
					addr_nxt = based_addr;
				end
				`MODE_BASED_IDX: begin
					addr_nxt = idx_addr;
				end
				`MODE_STACK: begin
					word_nxt      = 1'b1;
					write_nxt     = push_op;
					push_data_nxt = stack_pair;
					addr_nxt      = push_op ? stack_dn : stack_ptr;
				end
				default: begin
					illegal_nxt = 1'b1;
					valid_nxt   = 1'b0;
				end
			endcase
		end
		// stack confined to high-speed RAM, word must fit
		if (mode_nxt == `MODE_STACK) begin
			// the two candidates always differ, so the compare picks one
			range_nxt = (addr_nxt == stack_dn) ? push_bad : pop_bad;
			if (stack_push_req && !stack_pop_req)
				push_data_nxt = 16'h0000;
		end
		// a faulted operand never reaches the memory port
		if (align_nxt || range_nxt)
			valid_nxt = 1'b0;
	end

	// ****************************************
	// output registers, address group
	// ****************************************
	// address shows even on an align or range fault, only valid is held low
	always @(posedge core_clk) begin
		if (!rst_n) begin
			addr_valid_r  <= 1'b0;
			eff_addr_r    <= 16'h0000;
			addr_mode_r   <= `MODE_NONE;
		end else begin
			addr_valid_r  <= valid_nxt;
			eff_addr_r    <= addr_nxt;
			addr_mode_r   <= mode_nxt;
		end
	end

	// ****************************************
	// output registers, access group
	// ****************************************
	// data and access kind stand one cycle only, idle clears them
	always @(posedge core_clk) begin
		if (!rst_n) begin
			word_access_r <= 1'b0;
			is_write_r    <= 1'b0;
			push_data_r   <= 16'h0000;
		end else begin
			word_access_r <= word_nxt;
			is_write_r    <= write_nxt;
			push_data_r   <= push_data_nxt;
		end
	end

	// ****************************************
	// output registers, fault group
	// ****************************************
	// flags recomputed every edge, no sticky state to clear
	always @(posedge core_clk) begin
		if (!rst_n) begin
			align_fault_r <= 1'b0;
			range_fault_r <= 1'b0;
			illegal_op_r  <= 1'b0;
		end else begin
			align_fault_r <= align_nxt;
			range_fault_r <= range_nxt;
			illegal_op_r  <= illegal_nxt;
		end
	end

endmodule

// ===== bench/opaddr_chk_sva.sv
// assertions on the address generator ports
`timescale 1ns/100ps
module opaddr_chk (
	input logic         core_clk,
	input logic         rst_n,
	input logic         dec_valid,
	input logic [7:0]   opcode,
	input logic [7:0]   operand_byte,
	input logic         stack_push_req,
	input logic         stack_pop_req,
	input logic         regset_sel0,
	input logic         regset_sel1,
	input logic [255:0] gpr_file,
	input logic [15:0]  stack_ptr,
	input logic         addr_valid_r,
	input logic [15:0]  eff_addr_r,
	input logic [2:0]   addr_mode_r,
	input logic         is_write_r,
	input logic [15:0]  push_data_r,
	input logic         align_fault_r,
	input logic         range_fault_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// stack requests override decode
	wire        go = dec_valid && !stack_push_req && !stack_pop_req;
	wire [7:0]  bk = {regset_sel1, regset_sel0, 6'h00};
	wire [15:0] hl = gpr_file[bk+48 +: 16];
	wire [15:0] de = gpr_file[bk+32 +: 16];
	wire [7:0]  rb = gpr_file[bk+24 +: 8];
	byte_a: assert property ($past(rst_n && go && opcode == 8'hf0) |->
		eff_addr_r == {($past(operand_byte) < 8'h20) ? 8'hff : 8'hfe, $past(operand_byte)})
		else $error("short address wrong");
	sfr_page_a: assert property ($past(rst_n && go && opcode == 8'hf4) |->
		eff_addr_r == {8'hff, $past(operand_byte)}) else $error("sfr address wrong");
	sfr_hole_a: assert property ($past(rst_n && go && opcode == 8'hf6)
		&& $past(operand_byte[7:4]) == 4'hd |-> range_fault_r && !addr_valid_r)
		else $error("sfr hole accepted");
	pair_even_a: assert property ($past(rst_n && go && opcode == 8'h89 && operand_byte[0])
		|-> align_fault_r && !addr_valid_r) else $error("odd saddrp accepted");
	sfrp_even_a: assert property ($past(rst_n && go && opcode == 8'ha9 && operand_byte[0])
		|-> align_fault_r && !addr_valid_r) else $error("odd sfrp accepted");
	based_sum_a: assert property ($past(rst_n && go && opcode == 8'hae) |->
		eff_addr_r == $past(hl) + $past(operand_byte) && addr_mode_r == 3'h4)
		else $error("based sum wrong");
	index_sum_a: assert property ($past(rst_n && go && opcode == 8'hab) |->
		eff_addr_r == $past(hl) + $past(rb)) else $error("indexed sum wrong");
	push_alt_a: assert property ($past(rst_n && go && opcode == 8'hb5) |->
		eff_addr_r == $past(stack_ptr) - 16'h0002 && push_data_r == $past(de) && is_write_r)
		else $error("push pair wrong");
	stack_ram_a: assert property (addr_valid_r && addr_mode_r == 3'h6 |->
		eff_addr_r >= 16'hfb00 && eff_addr_r <= 16'hfefe) else $error("stack outside ram");
endmodule
bind operand_address_generator opaddr_chk u_opaddr_chk (.core_clk(core_clk),
	.rst_n(rst_n), .dec_valid(dec_valid), .opcode(opcode), .operand_byte(operand_byte),
	.stack_push_req(stack_push_req), .stack_pop_req(stack_pop_req), .regset_sel0(regset_sel0),
	.regset_sel1(regset_sel1), .gpr_file(gpr_file), .stack_ptr(stack_ptr),
	.addr_valid_r(addr_valid_r), .eff_addr_r(eff_addr_r), .addr_mode_r(addr_mode_r),
	.is_write_r(is_write_r), .push_data_r(push_data_r), .align_fault_r(align_fault_r),
	.range_fault_r(range_fault_r));

// ===== bench/operand_address_generator_tb_top.sv
// self-checking bench for the address generator
`timescale 1ns/100ps
module operand_address_generator_tb_top;
	logic         core_clk, rst_n, dec_valid, stack_push_req, stack_pop_req;
	logic         regset_sel0, regset_sel1, addr_valid_r, word_access_r, is_write_r;
	logic         align_fault_r, range_fault_r, illegal_op_r;
	logic [7:0]   opcode, operand_byte;
	logic [255:0] gpr_file;
	logic [15:0]  stack_ptr, eff_addr_r, push_data_r;
	logic [2:0]   addr_mode_r;
	logic [31:0]  seed;
	logic [7:0]   ops [20] = '{8'hf0, 8'hf2, 8'h11, 8'h89, 8'hf4, 8'hf6, 8'ha9, 8'h85, 8'h87,
		8'hae, 8'hab, 8'haa, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7};
	int           bad_count, total_checks, i, j;
	operand_address_generator u_operand_address_generator (.core_clk(core_clk), .rst_n(rst_n),
		.dec_valid(dec_valid), .opcode(opcode), .operand_byte(operand_byte),
		.stack_push_req(stack_push_req), .stack_pop_req(stack_pop_req),
		.regset_sel0(regset_sel0), .regset_sel1(regset_sel1), .gpr_file(gpr_file),
		.stack_ptr(stack_ptr), .addr_valid_r(addr_valid_r), .eff_addr_r(eff_addr_r),
		.addr_mode_r(addr_mode_r), .word_access_r(word_access_r), .is_write_r(is_write_r),
		.push_data_r(push_data_r), .align_fault_r(align_fault_r),
		.range_fault_r(range_fault_r), .illegal_op_r(illegal_op_r));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// drive one request, model it, compare one cycle later
	task automatic step(input logic dv, input logic [7:0] op, b, input logic pu, po);
		logic [15:0] hl, ea, pd;
		logic [2:0]  md;
		logic        w, wr, al, rg, il, sk;
		logic [40:0] ex, mk, got;
		int          k;
		begin
			{dec_valid, opcode, operand_byte, stack_push_req, stack_pop_req} = {dv, op, b, pu, po};
			k = {regset_sel1, regset_sel0} * 64;
			hl = gpr_file[k+48 +: 16];
			{ea, pd, md, w, wr, al, rg, il} = '0;
			sk = pu | po | (dv && op[7:3] == 5'h16);
			if (sk) begin
				md = 3'h6;
				w = 1'b1;
				wr = pu | (!po && op[0]);
				ea = wr ? stack_ptr - 16'h0002 : stack_ptr;
				pd = (pu | po) ? 16'h0000 : gpr_file[k+op[2:1]*16 +: 16];
				rg = ea < 16'hfb00 || ea > 16'hfefe;
			end else if (dv) begin
				case (op)
				8'hf0, 8'hf2, 8'h11, 8'h89: begin
					md = 3'h1;
					ea = {(b < 8'h20) ? 8'hff : 8'hfe, b};
					w = op == 8'h89;
					wr = op == 8'hf2 || op == 8'h11;
				end
				8'hf4, 8'hf6, 8'ha9: begin
					md = 3'h2;
					ea = {8'hff, b};
					w = op == 8'ha9;
					wr = op == 8'hf6;
					rg = b[7:4] == 4'hd;
				end
				8'h85, 8'h87: begin
					md = 3'h3;
					ea = op[1] ? hl : gpr_file[k+32 +: 16];
				end
				8'hae, 8'hab, 8'haa: begin
					md = op[2] ? 3'h4 : 3'h5;
					ea = hl + (op[2] ? b : gpr_file[k+(op[0] ? 24 : 16) +: 8]);
				end
				default: il = 1'b1;
				endcase
				al = w && b[0];
			end
			ex = {(pu | po | dv) && !il && !al && !rg, ea, md, w, wr, pd, al, rg, il};
			// faulted results only promise valid, the flags and, for align or range faults, the address
			mk = il ? 41'h10000000007 : (al | rg) ? 41'h1ffff000007 : '1;
			@(posedge core_clk);
			#1;
			got = {addr_valid_r, eff_addr_r, addr_mode_r, word_access_r, is_write_r,
				push_data_r, align_fault_r, range_fault_r, illegal_op_r};
			total_checks++;
			if ((got & mk) !== (ex & mk)) begin
				bad_count++;
				$display("[ERR] %0t op %h got %h exp %h", $time, op, got, ex);
			end
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{rst_n, dec_valid, stack_push_req, stack_pop_req, regset_sel0, regset_sel1} = 6'h00;
		{opcode, operand_byte, gpr_file, stack_ptr} = {16'h0000, 256'h0, 16'hfe00};
		{bad_count, total_checks, seed} = {32'h0, 32'h0, 32'h116ca};
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1'b1;
		step(1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
		$display("reset test done");
		gpr_file[48 +: 24] = 24'hfff8ff;
		step(1'b1, 8'hf0, 8'h1f, 1'b0, 1'b0);
		step(1'b1, 8'hf2, 8'h20, 1'b0, 1'b0);
		step(1'b1, 8'hf0, 8'h00, 1'b0, 1'b0);
		step(1'b1, 8'hf4, 8'h00, 1'b0, 1'b0);
		step(1'b1, 8'hf4, 8'hcf, 1'b0, 1'b0);
		step(1'b1, 8'hf6, 8'hd0, 1'b0, 1'b0);
		step(1'b1, 8'hf4, 8'he0, 1'b0, 1'b0);
		step(1'b1, 8'hf6, 8'h20, 1'b0, 1'b0);
		step(1'b1, 8'h89, 8'h31, 1'b0, 1'b0);
		step(1'b1, 8'ha9, 8'h21, 1'b0, 1'b0);
		step(1'b1, 8'hae, 8'h10, 1'b0, 1'b0);
		step(1'b1, 8'hab, 8'h00, 1'b0, 1'b0);
		step(1'b1, 8'h85, 8'h00, 1'b0, 1'b0);
		step(1'b1, 8'hb5, 8'h00, 1'b0, 1'b0);
		stack_ptr = 16'hfb00;
		step(1'b1, 8'hf0, 8'h05, 1'b1, 1'b1);
		step(1'b1, 8'hb4, 8'h00, 1'b0, 1'b0);
		$display("directed test done");
		for (i = 0; i < 500; i++) begin
			for (j = 0; j < 8; j++) begin
				seed = lfsr(seed);
				gpr_file[j*32 +: 32] = seed;
			end
			{regset_sel1, regset_sel0} = seed[1:0];
			stack_ptr = {4'hf, seed[13:2]};
			seed = lfsr(lfsr(seed));
			step(seed[31:30] != 2'h0, seed[4:0] < 5'h14 ? ops[seed[4:0]] : seed[15:8],
				seed[23:16], &seed[26:24], &seed[29:27]);
		end
		$display("random test done");
		results();
	end
endmodule
